// ===== src/sfsr_pkg.sv
// constants for the sample queue status and read-out block
// Behaviour
// [R1] The fill-level flag is set while the stored sample count is at least the fill level.
// [R2] The fill-level flag clears below the fill level; it sits at bit 1 and resets to zero.
// [R3] Each flag's interrupt rises and falls with its flag, with no latching or acknowledge.
// [R4] The empty flag is high when the enabled queue is unfilled and as the last entry is read.
// [R5] The empty flag is high after a successful clear command.
// [R6] While the queue is disabled the empty flag at bit 0 reads one, also its reset value.
// [R7] The empty flag is low whenever one or more samples are held.
// [R8] A checked channel's stored result at or above the upper limit sets the upper hit flag.
// [R9] A checked channel's stored result at or below the lower limit sets the lower hit flag.
// [R10] The limit register is read/write at address 0x3C and resets to 0xFFF000.
// [R11] The host keeps the limits static, flushing and restarting conversion after a change.
// [R12] A read of the 16-bit read-only data address 0x3D pops and returns the oldest sample.
// [R13] On overflow stop mode drops the new sample, streaming the oldest; lost flag bit 2 sets.
// [R14] The lost flag and both limit flags clear once the queue has been emptied.
// [R15] Reading status changes no flag; flags move only on fill, drain, clear or disable. The fill-level flag also moves when fillLevel changes.
package sfsr_pkg;
  localparam int          DEPTH       = 256;
  localparam int          DATA_W      = 16;
  localparam int          CHANNELS    = 16;
  localparam int          ADDR_W      = 6;
  localparam int          LIMIT_W     = 24;
  localparam int          STATUS_W    = 8;
  localparam int          FLAG_N      = 5;
  localparam logic [5:0]  LIMITS_ADDR = 6'h3C;
  localparam logic [5:0]  DATA_ADDR   = 6'h3D;
  localparam logic [23:0] LIMITS_RST  = 24'hFFF000;
  localparam int          UPPER_MSB   = 23;
  localparam int          UPPER_LSB   = 12;
  localparam int          LOWER_MSB   = 11;
  localparam int          LOWER_LSB   = 0;
  localparam int          CMP_MSB     = 15;
  localparam int          CMP_LSB     = 4;
  localparam int          EMPTY_BIT   = 0;
  localparam int          LEVEL_BIT   = 1;
  localparam int          LOST_BIT    = 2;
  localparam int          LOWER_BIT   = 3;
  localparam int          UPPER_BIT   = 4;
  localparam logic [4:0]  FLAGS_RST   = 5'h01;
endpackage : sfsr_pkg

// ===== src/sfsr_sample_queue.sv
// sample queue with status flags, limit compare and pop-on-read data port
`timescale 1ns/1ps
module sfsr_sample_queue #(
  parameter int DEPTH    = sfsr_pkg::DEPTH,
  parameter int CHANNELS = sfsr_pkg::CHANNELS,
  parameter int AW       = $clog2(DEPTH),
  parameter int CW       = $clog2(CHANNELS)
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // queue control levels
  input  wire logic                          queueEnable,
  input  wire logic                          clearCmd,
  input  wire logic                          streamMode,
  input  wire logic [AW:0]                   fillLevel,
  input  wire logic [CHANNELS-1:0]           channel_limit_check_enable,
  // conversion results
  input  wire logic                          sampleValid,
  input  wire logic [sfsr_pkg::DATA_W-1:0]   sampleData,
  input  wire logic [CW-1:0]                 sampleChannel,
  // register port
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  input  wire logic [sfsr_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [sfsr_pkg::LIMIT_W-1:0]  regWrData,
  output logic      [sfsr_pkg::LIMIT_W-1:0]  regRdData,
  output logic                               regRdValid,
  // status and interrupts
  output logic      [sfsr_pkg::STATUS_W-1:0] queueFlags,
  output logic      [sfsr_pkg::FLAG_N-1:0]   flagIrq
);
  import sfsr_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [AW-1:0]                wrPtr;
    logic [AW-1:0]                rdPtr;
    logic [AW:0]                  count;
    logic [LIMIT_W-1:0]           limits;
    logic [FLAG_N-1:0]            flags;
    logic [FLAG_N-1:0]            irq;
    logic [LIMIT_W-1:0]           rdData;
    logic                         rdValid;
  } sfsr_state_s;

  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_COUNT  = (AW+1)'(1);
  localparam logic [AW-1:0] ONE_PTR  = AW'(1);

  sfsr_state_s state_r;
  sfsr_state_s state_nxt;

  logic flush;
  logic dataRead;
  logic popReq;
  logic full;
  logic pushOk;
  logic dropOldest;
  logic limitCheck;
  logic [UPPER_MSB-UPPER_LSB:0] sampleTop;

  always_comb
  begin
    state_nxt  = state_r;
    flush      = !queueEnable || clearCmd;
    dataRead   = regRead && (regAddr == DATA_ADDR);
    popReq     = dataRead && (state_r.count != '0) && !flush;
    full       = (state_r.count == FULL_COUNT);
    // a pop in the same cycle frees room, so only a full queue without pop overflows
    pushOk     = sampleValid && !flush && (!full || popReq);
    dropOldest = sampleValid && !flush && full && !popReq && streamMode; // R13
    limitCheck = channel_limit_check_enable[sampleChannel];
    sampleTop  = sampleData[CMP_MSB:CMP_LSB];

    state_nxt.rdValid = regRead;
    state_nxt.rdData  = '0;
    if (regRead && (regAddr == LIMITS_ADDR))
    begin
      state_nxt.rdData = state_r.limits;
    end
    else if (dataRead && (state_r.count != '0))
    begin
      state_nxt.rdData = {{(LIMIT_W-DATA_W){1'b0}}, state_r.mem[state_r.rdPtr]}; // R12
    end

    if (regWrite && (regAddr == LIMITS_ADDR))
    begin
      state_nxt.limits = regWrData; // R10
    end

    if (popReq)
    begin
      state_nxt.rdPtr = state_r.rdPtr + ONE_PTR; // R12
      state_nxt.count = state_r.count - ONE_COUNT;
    end

    if (pushOk || dropOldest)
    begin
      state_nxt.mem[state_r.wrPtr] = sampleData;
      state_nxt.wrPtr              = state_r.wrPtr + ONE_PTR;
      if (pushOk)
      begin
        state_nxt.count = state_nxt.count + ONE_COUNT;
      end
      else
      begin
        state_nxt.rdPtr = state_r.rdPtr + ONE_PTR; // R13
      end
      if (limitCheck && (sampleTop >= state_r.limits[UPPER_MSB:UPPER_LSB]))
      begin
        state_nxt.flags[UPPER_BIT] = 1'b1; // R8
      end
      if (limitCheck && (sampleTop <= state_r.limits[LOWER_MSB:LOWER_LSB]))
      begin
        state_nxt.flags[LOWER_BIT] = 1'b1; // R9
      end
    end

    if (sampleValid && !flush && full && !popReq)
    begin
      state_nxt.flags[LOST_BIT] = 1'b1; // R13
    end

    if (flush)
    begin
      state_nxt.wrPtr = '0;
      state_nxt.rdPtr = '0;
      state_nxt.count = '0;
    end

    if (state_nxt.count == '0)
    begin
      state_nxt.flags[LOST_BIT]  = 1'b0; // R14
      state_nxt.flags[UPPER_BIT] = 1'b0; // R14
      state_nxt.flags[LOWER_BIT] = 1'b0; // R14
    end
    // flags derive from the next count, fillLevel and queue events only, so a status read moves nothing
    state_nxt.flags[EMPTY_BIT] = (state_nxt.count == '0); // R4 R5 R6 R7 R15
    state_nxt.flags[LEVEL_BIT] = (state_nxt.count >= fillLevel); // R1 R2
    state_nxt.irq              = state_nxt.flags; // R3
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r        <= '0;
      state_r.limits <= LIMITS_RST;
      state_r.flags  <= FLAGS_RST;
      state_r.irq    <= FLAGS_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign regRdData  = state_r.rdData;
  assign regRdValid = state_r.rdValid;
  assign queueFlags = {{(STATUS_W-FLAG_N){1'b0}}, state_r.flags};
  assign flagIrq    = state_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // empty and fill-level flags against the stored count
  empty_flag_a: assert property (state_r.flags[EMPTY_BIT] == (state_r.count == '0)) // R7
    else $error("empty flag disagrees with count");
  last_read_empty_a: assert property (popReq && !sampleValid && // R4
    state_r.count == ONE_COUNT |=> state_r.flags[EMPTY_BIT])
    else $error("last read left the queue flagged non-empty");
  clear_empty_a: assert property (clearCmd |=> state_r.flags[EMPTY_BIT] && // R5
    state_r.count == '0)
    else $error("clear command left samples behind");
  disabled_empty_a: assert property (!queueEnable |=> // R6
    state_r.flags[EMPTY_BIT] ##0 state_r.count == '0)
    else $error("disabled queue not empty");
  push_filled_a: assert property (sampleValid && !flush |=> !state_r.flags[EMPTY_BIT]) // R7
    else $error("stored sample left the queue flagged empty");
  fill_level_a: assert property (##1 state_r.flags[LEVEL_BIT] == // R1
    (state_r.count >= $past(fillLevel)))
    else $error("fill level flag disagrees with count");

  // interrupts and stability of the status word
  irq_follows_a: assert property (state_r.irq == state_r.flags) // R3
    else $error("interrupt differs from flag");
  status_hold_a: assert property (!sampleValid && !popReq && !flush && // R15
    $stable(fillLevel) && $past(reset_n) |=> $stable(state_r.flags))
    else $error("flags moved without a queue event");

  // register port
  limit_write_a: assert property (regWrite && regAddr == LIMITS_ADDR |=> // R10
    state_r.limits == $past(regWrData))
    else $error("limit write not stored");
  read_answer_a: assert property (##1 regRdValid == $past(regRead)) // R12
    else $error("read answer not one cycle after the strobe");
  pop_count_a: assert property (popReq && !sampleValid |=> // R12
    state_r.count == $past(state_r.count) - ONE_COUNT)
    else $error("data read did not pop");
  pop_data_a: assert property (popReq |=> regRdValid && // R12
    regRdData[DATA_W-1:0] == $past(state_r.mem[state_r.rdPtr]))
    else $error("data read returned wrong sample");

  // limit compare and overflow
  upper_hit_a: assert property ((pushOk || dropOldest) && limitCheck && // R8
    sampleTop >= state_r.limits[UPPER_MSB:UPPER_LSB] |=> state_r.flags[UPPER_BIT])
    else $error("upper limit hit not flagged");
  lower_hit_a: assert property ((pushOk || dropOldest) && limitCheck && // R9
    sampleTop <= state_r.limits[LOWER_MSB:LOWER_LSB] |=> state_r.flags[LOWER_BIT])
    else $error("lower limit hit not flagged");
  overflow_lost_a: assert property (sampleValid && full && !popReq && !flush |=> // R13
    state_r.flags[LOST_BIT] && state_r.count == FULL_COUNT)
    else $error("overflow not flagged");
  stop_drop_a: assert property (sampleValid && full && !popReq && !flush && // R13
    !streamMode |=> $stable(state_r.wrPtr) && $stable(state_r.rdPtr))
    else $error("stop mode overflow moved the queue");
  stream_drop_a: assert property (dropOldest |=> state_r.count == FULL_COUNT && // R13
    state_r.rdPtr == $past(state_r.rdPtr) + ONE_PTR)
    else $error("streaming overflow kept the oldest sample");
  emptied_clear_a: assert property (state_r.count == '0 |-> // R14
    state_r.flags[LOST_BIT+2:LOST_BIT] == 3'h0)
    else $error("sticky flags survive empty queue");
endmodule : sfsr_sample_queue

// ===== dv/sfsr_host_model.sv
// host side model: issues register accesses to the sample queue
`timescale 1ns/1ps
module sfsr_host_model (
  // clock
  input  wire logic                         clk,
  // register port
  output logic                              regWrite,
  output logic                              regRead,
  output logic [sfsr_pkg::ADDR_W-1:0]       regAddr,
  output logic [sfsr_pkg::LIMIT_W-1:0]      regWrData
);
  import sfsr_pkg::*;
  initial {regWrite, regRead, regAddr, regWrData} = '0;
  // one strobe cycle per access; a data read pops, so never repeat it blindly
  task automatic acc(input logic wr, input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    regWrite  <= wr;
    regRead   <= !wr;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
  endtask : acc
endmodule : sfsr_host_model

// ===== dv/sample_fifo_status_readout_tb.sv
// self-checking bench for the sample queue status and read-out block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL %0t value mismatch", $time); end end
module sample_fifo_status_readout_tb;
  import sfsr_pkg::*;
  logic        clk = 0, reset_n = 0, queueEnable = 0, clearCmd = 0;
  logic        streamMode = 0, sampleValid = 0, regWrite, regRead, regRdValid;
  logic [2:0]  fillLevel = 3'h2;
  logic [15:0] chkEn = 16'h5AF3, sampleData = 16'h0000;
  logic [3:0]  sampleChannel = 4'h0;
  logic [5:0]  regAddr;
  logic [23:0] regWrData, regRdData, lim = 24'hFFF000;
  logic [7:0]  queueFlags;
  logic [4:0]  flagIrq;
  int          err_count = 0, n_compared = 0, seed = 51800, q[$];
  bit          lost, up, lo;
  always #25 clk = ~clk;
  sfsr_host_model u_host (.clk(clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData));
  sfsr_sample_queue #(.DEPTH(4)) u_dut (.clk(clk), .reset_n(reset_n),
    .queueEnable(queueEnable), .clearCmd(clearCmd), .streamMode(streamMode),
    .fillLevel(fillLevel), .channel_limit_check_enable(chkEn), .sampleValid(sampleValid),
    .sampleData(sampleData), .sampleChannel(sampleChannel), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .queueFlags(queueFlags), .flagIrq(flagIrq));
  task automatic complete_run;
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check;
    logic [7:0] e;
    #1;
    if (q.size() == 0) {lost, up, lo} = '0;
    e = {3'h0, up, lo, lost, q.size() >= fillLevel, q.size() == 0};
    `CHK(queueFlags, e)
    `CHK(flagIrq, e[4:0])
  endtask : check
  task automatic push;
    logic [15:0] d;
    logic [3:0]  ch;
    d = 16'($random(seed));
    ch = 4'($random(seed));
    @(posedge clk);
    sampleValid   <= 1'b1;
    sampleData    <= d;
    sampleChannel <= ch;
    @(posedge clk);
    sampleValid <= 1'b0;
    if (q.size() == 4) lost = 1;
    if (q.size() == 4 && streamMode) void'(q.pop_front());
    if (q.size() < 4)
    begin
      q.push_back(d);
      up |= chkEn[ch] && d[15:4] >= lim[23:12];
      lo |= chkEn[ch] && d[15:4] <= lim[11:0];
    end
    check();
  endtask : push
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    u_host.acc(1'b0, a, 24'h0);
    #1;
    `CHK(regRdValid, 1'b1)
    `CHK(regRdData, e)
    @(posedge clk);
    #1;
    `CHK(regRdValid, 1'b0)
    `CHK(regRdData, 24'h0)
  endtask : rd
  task automatic pop;
    int e;
    e = q.size() ? q.pop_front() : 0;
    rd(DATA_ADDR, 24'(e));
    check();
  endtask : pop
  task automatic ctl(input logic en, input logic clr);
    @(posedge clk);
    queueEnable <= en;
    clearCmd    <= clr;
    @(posedge clk);
    clearCmd <= 1'b0;
    if (!en || clr) q.delete();
    check();
  endtask : ctl
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    check();
    rd(LIMITS_ADDR, LIMITS_RST);
    rd(6'h10, 24'h0);
    u_host.acc(1'b1, DATA_ADDR, 24'h00ABCD);
    rd(LIMITS_ADDR, lim);
    ctl(1'b1, 1'b0);
    pop();
    lim = 24'h8003FF;
    u_host.acc(1'b1, LIMITS_ADDR, lim);
    rd(LIMITS_ADDR, lim);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      streamMode <= m[0];
      fillLevel  <= 3'($random(seed));
      // flush after a limit change so every compare uses the new limits
      ctl(1'b1, 1'b1);
      repeat (6) push();
      repeat (5) pop();
    end
    repeat (2) push();
    ctl(1'b0, 1'b0);
    ctl(1'b1, 1'b0);
    push();
    ctl(1'b1, 1'b1);
    complete_run();
  end
  initial
  begin
    #1000000;
    err_count++;
    complete_run();
  end
endmodule : sample_fifo_status_readout_tb
